//--- drive_seq_regs.svh
`ifndef DRIVE_SEQ_REGS_SVH
`define DRIVE_SEQ_REGS_SVH

// Register byte offsets on the Avalon-MM slave
`define REG_SEQ_OFS       4'h0
`define REG_DEST_OFS      4'h4
`define REG_CFG_OFS       4'h8
`define REG_STATUS_OFS    4'hc

// Sequencing register field positions
`define SEQ_RUN_FWD       0
`define SEQ_JOG           1
`define SEQ_RUN_REV       2
`define SEQ_DIR           3
`define SEQ_RUN           4
`define SEQ_FWD_LIM       5
`define SEQ_REV_LIM       6
`define SEQ_NOT_STOP      7
`define SEQ_LATCH_EN      8
`define SEQ_JOG_REV       9
`define SEQ_W             10

// Digital I/O configuration field positions
`define CFG_INV_POS       8
`define DEST_CODE_W       4

// Reset values
`define SEQ_RESET         10'h000
`define DEST_RESET        4'h0
`define CFG_RESET         1'b0

// Timing, in the unit of each name
`define CLK_MHZ           10
`define SEQ_TICK_US       4000
`define LIM_TICK_US       250
`define DIO_FILT_US       500
`define FILT_LATENCY      4

`endif

//--- drive_seq_pkg.sv
`default_nettype none
package drive_seq_pkg;

  // Destination codes of a digital I/O
  typedef enum logic [3:0] {
    DEST_NONE      = 4'h0,
    DEST_HW_ENABLE = 4'h1,
    DEST_RUN_FWD   = 4'h2,
    DEST_JOG       = 4'h3,
    DEST_RUN_REV   = 4'h4,
    DEST_DIR       = 4'h5,
    DEST_RUN       = 4'h6,
    DEST_FWD_LIM   = 4'h7,
    DEST_REV_LIM   = 4'h8,
    DEST_NOT_STOP  = 4'h9,
    DEST_JOG_REV   = 4'ha
  } dio_dest_e;

  // Jog state machine
  typedef enum logic [2:0] {
    JOG_IDLE = 3'b001,
    JOG_FWD  = 3'b010,
    JOG_REV  = 3'b100
  } jog_state_e;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_s;

  // Avalon-MM answer of the slave
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } avs_rsp_s;

  // Sequencing bits as sampled
  typedef struct packed {
    logic run_fwd;
    logic jog;
    logic run_rev;
    logic dir;
    logic run;
    logic not_stop;
    logic jog_rev;
  } seq_bits_s;

endpackage : drive_seq_pkg
`default_nettype wire

//--- in_filter.sv
`default_nettype none
module in_filter #(
  parameter int FILT_CYCLES = 1
) (
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  input  wire logic i_pin,
  output var  logic o_level
);
  localparam logic [15:0] FILT_M1 = 16'(FILT_CYCLES - 1);

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        level;
    logic [15:0] cnt;
  } filt_s;

  filt_s st;
  filt_s next_st;

  // Three-stage synchroniser, then a steady-time filter on agreeing stages
  always_comb begin
    next_st       = st;
    next_st.sync1 = i_pin;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    if (st.sync2 == st.sync3) begin
      if (st.sync3 == st.level) begin
        next_st.cnt = 16'h0000;
      end else if (st.cnt >= FILT_M1) begin
        next_st.level = st.sync3;
        next_st.cnt   = 16'h0000;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

  // Level only moves to a value both late stages already showed
  AST_FILT_AGREE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $changed(st.level) |-> ($past(st.sync3) == st.level)) // [RQ12]
    else $error("filter changed to a value not seen on the synchroniser");

endmodule : in_filter
`default_nettype wire

//--- drive_run_sequencer_enable_gating.sv
// How it works
// [RQ1] An input-mode digital I/O routed to hardware enable acts as fast disable.
// [RQ2] Drive enable is fast-disable level after invert ANDed with safety terminal.
// [RQ3] Safety terminal low removes gate drive at once and status within 4 ms.
// [RQ4] Fast-disable input deactivation disables the drive well inside 600 us.
// [RQ5] Controller should wire its enable to both safety and fast-disable inputs.
// [RQ6] Safety and fast enables must be independent, no direct link between them.
// [RQ7] Run fwd/rev or run plus direction schemes; sequencing bits sampled every 4 ms.
// [RQ8] Controller drives only the chosen scheme's bit pair.
// [RQ9] With latching enabled, run bits latch while not-stop is one.
// [RQ10] Not-stop zero clears all run latches and holds them clear.
// [RQ11] Jog starts only from standstill with no normal run request active.
// [RQ12] Limit inputs answer within 750 us: 500 us filter plus 250 us sampling.
// [RQ13] A limit event stops the motor with zero ramp rate.
// [RQ14] Limit stops depend on direction so the motor can move away.
// [RQ15] Forward limit for positive, reverse for negative, either at zero reference.
// [RQ16] Hardware enable status held zero on fast disable or power-stage trip.
// [RQ17] Software bit writes act at the next sampling instant of that bit.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none
`include "drive_seq_regs.svh"
module drive_run_sequencer_enable_gating #(
  parameter int NUM_DIO         = 6,
  parameter int REF_W           = 16,
  parameter int SEQ_TICK_CYCLES = `SEQ_TICK_US * `CLK_MHZ,
  parameter int DIO_FILT_CYCLES = `DIO_FILT_US * `CLK_MHZ - `FILT_LATENCY
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_arst_n,
  input  wire drive_seq_pkg::avs_req_s  i_avs,
  output var  drive_seq_pkg::avs_rsp_s  o_avs,
  input  wire logic                     i_safety_enable_terminal,
  input  wire logic [NUM_DIO-1:0]       i_dio,
  input  wire logic signed [REF_W-1:0]  i_speed_ref_sum,
  input  wire logic                     i_motor_stopped,
  input  wire logic                     i_power_stage_trip,
  output var  logic                     o_gate_drive_en,
  output var  logic                     o_hardware_enable_status,
  output var  logic                     o_run,
  output var  logic                     o_reverse,
  output var  logic                     o_jog,
  output var  logic                     o_zero_ramp_stop
);
  import drive_seq_pkg::*;

  localparam int          DEST_W     = `DEST_CODE_W * NUM_DIO;
  localparam int          LIM_CYCLES = `LIM_TICK_US * `CLK_MHZ;
  localparam logic [15:0] SEQ_M1     = 16'(SEQ_TICK_CYCLES - 1);
  localparam logic [15:0] LIM_M1     = 16'(LIM_CYCLES - 1);

  typedef struct packed {
    avs_rsp_s            rsp;
    logic [`SEQ_W-1:0]   seq_reg;
    logic [DEST_W-1:0]   dest;
    logic [NUM_DIO-1:0]  in_mode;
    logic [NUM_DIO-1:0]  invert;
    logic [15:0]         seq_cnt;
    logic [15:0]         lim_cnt;
    seq_bits_s           smp;
    logic                l_fwd;
    logic                l_rev;
    logic                l_run;
    logic                lf;
    logic                lr;
    jog_state_e          jog;
    logic                gate;
    logic                hw_status;
    logic                run;
    logic                reverse;
    logic                jog_out;
    logic                zstop;
  } st_s;

  st_s                st;
  st_s                next_st;
  logic [NUM_DIO-1:0] flt;
  logic [NUM_DIO-1:0] dval;
  logic               sto;
  logic               seq_tick;
  logic               lim_tick;
  logic               fok;
  logic               run_req;

  // Merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction : be_merge

  // OR of all input-mode I/O routed to one destination
  function automatic logic routed(input dio_dest_e code, input logic [NUM_DIO-1:0] val,
                                  input logic [NUM_DIO-1:0] mode,
                                  input logic [DEST_W-1:0] dest);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_DIO; i++) begin
      if (mode[i] && dest[i*`DEST_CODE_W +: `DEST_CODE_W] == code) r = r | val[i];
    end
    return r;
  endfunction : routed

  // Synchronise and filter every digital I/O
  generate
    for (genvar g = 0; g < NUM_DIO; g++) begin : g_dio
      in_filter #(.FILT_CYCLES(DIO_FILT_CYCLES)) u_filt (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_dio[g]),
        .o_level   (flt[g])
      );
    end
  endgenerate

  // Safety terminal passes the synchroniser only
  in_filter #(.FILT_CYCLES(1)) u_sto (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_pin     (i_safety_enable_terminal),
    .o_level   (sto)
  );

  // Invert applied before routing; sampling ticks
  assign dval     = flt ^ st.invert;
  assign seq_tick = (st.seq_cnt == SEQ_M1);
  assign lim_tick = (st.lim_cnt == LIM_M1);

  // Fast-disable level: AND of all input-mode I/O routed to hardware enable
  always_comb begin
    fok = 1'b1;
    for (int i = 0; i < NUM_DIO; i++) begin
      if (st.in_mode[i] && st.dest[i*`DEST_CODE_W +: `DEST_CODE_W] == DEST_HW_ENABLE
          && !dval[i]) begin
        fok = 1'b0; // [RQ1]
      end
    end
  end

  // Next-state logic: bus slave, sampling, sequencer, limits, enable
  always_comb begin
    seq_bits_s   s;
    logic        eff_fwd;
    logic        eff_rev;
    logic        eff_run;
    logic        rev_dir;
    logic [31:0] m;
    s       = st.smp;
    eff_fwd = 1'b0;
    eff_rev = 1'b0;
    eff_run = 1'b0;
    rev_dir = 1'b0;
    m       = 32'h0000_0000;
    run_req = 1'b0;
    next_st = st;

    next_st.seq_cnt = seq_tick ? 16'h0000 : st.seq_cnt + 16'h0001;
    next_st.lim_cnt = lim_tick ? 16'h0000 : st.lim_cnt + 16'h0001;

    // One wait state, then the answer; write lands on the completing edge
    next_st.rsp.waitrequest = 1'b1;
    if ((i_avs.read || i_avs.write) && st.rsp.waitrequest) begin
      next_st.rsp.waitrequest = 1'b0;
      if (i_avs.read) begin
        if (i_avs.address == `REG_SEQ_OFS) begin
          next_st.rsp.readdata = 32'(st.seq_reg);
        end else if (i_avs.address == `REG_DEST_OFS) begin
          next_st.rsp.readdata = 32'(st.dest);
        end else if (i_avs.address == `REG_CFG_OFS) begin
          next_st.rsp.readdata = 32'(st.in_mode) | (32'(st.invert) << `CFG_INV_POS);
        end else if (i_avs.address == `REG_STATUS_OFS) begin
          next_st.rsp.readdata = 32'({flt, 1'b0, sto, st.zstop, st.jog_out, st.reverse,
                                      st.run, st.gate, st.hw_status});
        end else begin
          next_st.rsp.readdata = 32'h0000_0000;
        end
      end
    end
    if (i_avs.write && !st.rsp.waitrequest) begin
      if (i_avs.address == `REG_SEQ_OFS) begin
        m               = be_merge(32'(st.seq_reg), i_avs.writedata, i_avs.byteenable);
        next_st.seq_reg = m[`SEQ_W-1:0]; // [RQ17]
      end else if (i_avs.address == `REG_DEST_OFS) begin
        m            = be_merge(32'(st.dest), i_avs.writedata, i_avs.byteenable);
        next_st.dest = m[DEST_W-1:0];
      end else if (i_avs.address == `REG_CFG_OFS) begin
        m               = be_merge(32'(st.in_mode) | (32'(st.invert) << `CFG_INV_POS),
                                   i_avs.writedata, i_avs.byteenable);
        next_st.in_mode = m[NUM_DIO-1:0];
        next_st.invert  = m[`CFG_INV_POS +: NUM_DIO];
      end
    end

    // Sequencing bits: software bit ORed with routed inputs, taken at the 4 ms tick
    if (seq_tick) begin
      s.run_fwd  = st.seq_reg[`SEQ_RUN_FWD]  | routed(DEST_RUN_FWD, dval, st.in_mode, st.dest);
      s.jog      = st.seq_reg[`SEQ_JOG]      | routed(DEST_JOG, dval, st.in_mode, st.dest);
      s.run_rev  = st.seq_reg[`SEQ_RUN_REV]  | routed(DEST_RUN_REV, dval, st.in_mode, st.dest);
      s.dir      = st.seq_reg[`SEQ_DIR]      | routed(DEST_DIR, dval, st.in_mode, st.dest);
      s.run      = st.seq_reg[`SEQ_RUN]      | routed(DEST_RUN, dval, st.in_mode, st.dest);
      s.not_stop = st.seq_reg[`SEQ_NOT_STOP] | routed(DEST_NOT_STOP, dval, st.in_mode, st.dest);
      s.jog_rev  = st.seq_reg[`SEQ_JOG_REV]  | routed(DEST_JOG_REV, dval, st.in_mode, st.dest);
      next_st.smp = s; // [RQ7] [RQ17]

      // Latches set while not-stop is one, cleared and held while it is zero
      if (st.seq_reg[`SEQ_LATCH_EN] && s.not_stop) begin
        next_st.l_fwd = st.l_fwd | s.run_fwd; // [RQ9]
        next_st.l_rev = st.l_rev | s.run_rev;
        next_st.l_run = st.l_run | s.run;
      end else begin
        next_st.l_fwd = 1'b0; // [RQ10]
        next_st.l_rev = 1'b0;
        next_st.l_run = 1'b0;
      end
      eff_fwd = st.seq_reg[`SEQ_LATCH_EN] ? next_st.l_fwd : s.run_fwd;
      eff_rev = st.seq_reg[`SEQ_LATCH_EN] ? next_st.l_rev : s.run_rev;
      eff_run = st.seq_reg[`SEQ_LATCH_EN] ? next_st.l_run : s.run;
      run_req = eff_fwd | eff_rev | eff_run;
      rev_dir = eff_run ? s.dir : (eff_rev & ~eff_fwd); // [RQ7]

      // Jog only from standstill on a new jog bit with no run request
      case (st.jog)
        JOG_IDLE: begin
          if (!run_req && i_motor_stopped) begin
            if (s.jog && !st.smp.jog) begin
              next_st.jog = JOG_FWD; // [RQ11]
            end else if (s.jog_rev && !st.smp.jog_rev) begin
              next_st.jog = JOG_REV; // [RQ11]
            end
          end
        end
        JOG_FWD: begin
          if (run_req || !s.jog) next_st.jog = JOG_IDLE;
        end
        JOG_REV: begin
          if (run_req || !s.jog_rev) next_st.jog = JOG_IDLE;
        end
        default: begin
          next_st.jog = JOG_IDLE;
        end
      endcase
      next_st.jog_out = (next_st.jog != JOG_IDLE);
      next_st.run     = run_req | next_st.jog_out;
      next_st.reverse = run_req ? rev_dir : (next_st.jog == JOG_REV);
    end

    // Limit bits taken at the 250 us tick
    if (lim_tick) begin
      next_st.lf = st.seq_reg[`SEQ_FWD_LIM] | routed(DEST_FWD_LIM, dval, st.in_mode, st.dest); // [RQ12]
      next_st.lr = st.seq_reg[`SEQ_REV_LIM] | routed(DEST_REV_LIM, dval, st.in_mode, st.dest);
    end

    // Direction-dependent zero-ramp stop
    if (i_speed_ref_sum > 0) begin
      next_st.zstop = st.lf; // [RQ13] [RQ14] [RQ15]
    end else if (i_speed_ref_sum < 0) begin
      next_st.zstop = st.lr; // [RQ14] [RQ15]
    end else begin
      next_st.zstop = st.lf | st.lr; // [RQ15]
    end

    // Gate drive follows safety AND fast level every cycle; status takes safety on the 4 ms tick, cleared at once by fast disable or trip
    next_st.gate = sto & fok; // [RQ2] [RQ3]
    if (!fok || i_power_stage_trip) begin
      next_st.hw_status = 1'b0; // [RQ4] [RQ16]
    end else if (seq_tick) begin
      next_st.hw_status = sto; // [RQ2] [RQ3]
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st                 <= '0;
      st.rsp.waitrequest <= 1'b1;
      st.seq_reg         <= `SEQ_RESET;
      st.dest            <= {NUM_DIO{`DEST_RESET}};
      st.in_mode         <= {NUM_DIO{`CFG_RESET}};
      st.invert          <= {NUM_DIO{`CFG_RESET}};
      st.jog             <= JOG_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_avs                    = st.rsp;
  assign o_gate_drive_en          = st.gate;
  assign o_hardware_enable_status = st.hw_status;
  assign o_run                    = st.run;
  assign o_reverse                = st.reverse;
  assign o_jog                    = st.jog_out;
  assign o_zero_ramp_stop         = st.zstop;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_tick_with_latch_stop;
    seq_tick && st.seq_reg[`SEQ_LATCH_EN] && !(st.seq_reg[`SEQ_NOT_STOP] |
      routed(DEST_NOT_STOP, dval, st.in_mode, st.dest));
  endsequence

  sequence s_latches_clear;
    !st.l_fwd && !st.l_rev && !st.l_run;
  endsequence

  AST_STO_GATE: assert property (!sto |=> !o_gate_drive_en) // [RQ3]
    else $error("gate drive stayed on with safety terminal low");

  AST_FAST_DISABLE: assert property (!fok |=> !o_gate_drive_en && !o_hardware_enable_status) // [RQ4]
    else $error("fast disable did not remove enable next cycle");

  AST_TRIP_HOLD: assert property (i_power_stage_trip |=> !o_hardware_enable_status) // [RQ16]
    else $error("enable status set during power-stage trip");

  AST_STATUS_RISE: assert property ($rose(o_hardware_enable_status) |->
    $past(seq_tick) && $past(sto) && $past(fok)) // [RQ2]
    else $error("enable status rose without tick, safety and fast level");

  AST_NOTSTOP_CLEAR: assert property (s_tick_with_latch_stop |=> s_latches_clear) // [RQ10]
    else $error("run latches not cleared by not-stop zero");

  AST_SEQ_STABLE: assert property (!seq_tick |=> $stable(o_run) && $stable(o_reverse)) // [RQ7]
    else $error("run outputs changed between sequencing samples");

  AST_JOG_BLOCKED: assert property (seq_tick && st.jog == JOG_IDLE && !i_motor_stopped
    |=> st.jog == JOG_IDLE) // [RQ11]
    else $error("jog started while motor not stopped");

  AST_LIM_FWD: assert property (st.lf && i_speed_ref_sum > 0 |=> o_zero_ramp_stop) // [RQ13]
    else $error("forward limit did not stop positive reference");

  AST_LIM_AWAY: assert property (st.lf && !st.lr && i_speed_ref_sum < 0
    |=> !o_zero_ramp_stop) // [RQ14]
    else $error("forward limit blocked motion away from it");

  AST_BUS_ONE_WAIT: assert property ((i_avs.read || i_avs.write) && o_avs.waitrequest
    |=> !o_avs.waitrequest ##1 o_avs.waitrequest) // [RQ17]
    else $error("bus answer not given after exactly one wait state");

endmodule : drive_run_sequencer_enable_gating
`default_nettype wire

//--- drive_partner_model.sv
`default_nettype none
module drive_partner_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_enable_cmd,
  input  wire logic       i_fast_stuck,
  input  wire logic       i_fwd_limit,
  input  wire logic       i_rev_limit,
  output var  logic       o_safety_enable_terminal,
  output var  logic [5:0] o_dio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic spare = 1'b0;

  // Spare pins float, so they show a level that changes every cycle
  always @(posedge i_sys_clk) begin
    spare <= !spare;
  end

  // Safety line has its own driver, not linked to the fast line
  assign o_safety_enable_terminal = i_enable_cmd;
  // One enable command feeds the fast line too; a fault may stick it high
  assign o_dio[0] = i_enable_cmd | i_fast_stuck;
  // Limit switches on their own pins
  assign o_dio[1] = i_fwd_limit;
  assign o_dio[2] = i_rev_limit;
  // No pin is routed to the run bits of the unused scheme
  assign o_dio[5:3] = {3{spare}};
endmodule : drive_partner_model
`default_nettype wire

//--- test_drive_run_sequencer_enable_gating.sv
`default_nettype none
module test_drive_run_sequencer_enable_gating;
  timeunit 1ns;
  timeprecision 1ns;
  import drive_seq_pkg::*;
  localparam int SEQ_T = 50;
  logic                     clk;
  logic                     arst_n;
  avs_req_s                 avs;
  avs_rsp_s                 rsp;
  logic                     sto;
  logic [5:0]               dio;
  logic signed [15:0]       sref;
  logic                     stopped;
  logic                     trip;
  logic                     en_cmd;
  logic                     stuck;
  logic                     flim;
  logic                     rlim;
  logic [5:0]               outs;
  logic [31:0]              q;
  int                       fail_count = 0;
  int                       checks_done = 0;

  drive_run_sequencer_enable_gating #(
    .SEQ_TICK_CYCLES(SEQ_T),
    .DIO_FILT_CYCLES(4)
  ) u_dut (
    .i_sys_clk                (clk),
    .i_arst_n                 (arst_n),
    .i_avs                    (avs),
    .o_avs                    (rsp),
    .i_safety_enable_terminal (sto),
    .i_dio                    (dio),
    .i_speed_ref_sum          (sref),
    .i_motor_stopped          (stopped),
    .i_power_stage_trip       (trip),
    .o_gate_drive_en          (outs[0]),
    .o_hardware_enable_status (outs[1]),
    .o_run                    (outs[2]),
    .o_reverse                (outs[3]),
    .o_jog                    (outs[4]),
    .o_zero_ramp_stop         (outs[5])
  );

  drive_partner_model u_partner (
    .i_sys_clk                (clk),
    .i_enable_cmd             (en_cmd),
    .i_fast_stuck             (stuck),
    .i_fwd_limit              (flim),
    .i_rev_limit              (rlim),
    .o_safety_enable_terminal (sto),
    .o_dio                    (dio)
  );

  // Clock at 10 MHz
  always #50 clk = ~clk;

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    chk(rsp.waitrequest, 1'b0, "waitrequest");
    q = rsp.readdata;
    avs <= '0;
  endtask : bus

  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(q, e, nm);
  endtask : rc

  // Wait a bounded time for an output to reach a level, then check it
  task automatic wo(input int i, input logic v, input int m, input string nm);
    int n;
    n = 0;
    while (outs[i] !== v && n < m) begin
      @(posedge clk);
      n++;
    end
    chk(outs[i], v, nm);
  endtask : wo

  // Long enough for one sequencing sample and its output update
  task automatic st;
    repeat (SEQ_T + 4) @(posedge clk);
  endtask : st

  task automatic t_regs;
    rc(4'h0, 32'h0, "seq reset");
    rc(4'h4, 32'h0, "dest reset");
    rc(4'h8, 32'h0, "cfg reset");
    bus(1'b1, 4'h2, 32'hffffffff);
    rc(4'h2, 32'h0, "unmapped");
    bus(1'b1, 4'h0, 32'h155);
    rc(4'h0, 32'h155, "seq readback");
    bus(1'b1, 4'h0, 32'h0);
    st();
    $display("test regs done");
  endtask : t_regs

  task automatic t_enable;
    bus(1'b1, 4'h4, 32'h1);
    en_cmd <= 1'b1;
    bus(1'b1, 4'h8, 32'h100);
    wo(0, 1'b1, 100, "gate output mode");
    bus(1'b1, 4'h8, 32'h101);
    wo(0, 1'b0, 6000, "gate fast off");
    wo(1, 1'b0, 2, "status fast off");
    bus(1'b1, 4'h8, 32'h1);
    wo(0, 1'b1, 100, "gate on");
    wo(1, 1'b1, 2 * SEQ_T + 10, "status on");
    rc(4'hc, 32'h143, "status word");
    trip <= 1'b1;
    wo(1, 1'b0, 2, "status trip");
    chk(outs[0], 1'b1, "gate trip");
    trip <= 1'b0;
    stuck <= 1'b1;
    en_cmd <= 1'b0;
    wo(0, 1'b0, 10, "gate safety off");
    wo(1, 1'b0, 2 * SEQ_T + 10, "status safety off");
    stuck <= 1'b0;
    en_cmd <= 1'b1;
    wo(0, 1'b1, 100, "gate back");
    $display("test enable done");
  endtask : t_enable

  task automatic t_schemes;
    logic [9:0] sv [7] = '{10'h001, 10'h004, 10'h005, 10'h010, 10'h018, 10'h008, 10'h000};
    logic [1:0] ex [7] = '{2'b01, 2'b11, 2'b01, 2'b01, 2'b11, 2'b00, 2'b00};
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, 4'h0, {22'h0, sv[k]});
      st();
      chk(outs[3:2], ex[k], "run and reverse");
    end
    $display("test schemes done");
  endtask : t_schemes

  task automatic t_latch;
    logic [9:0] sv [4] = '{10'h181, 10'h180, 10'h100, 10'h101};
    logic       ex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h0, {22'h0, sv[k]});
      st();
      chk(outs[2], ex[k], "latched run");
    end
    bus(1'b1, 4'h0, 32'h0);
    st();
    $display("test latch done");
  endtask : t_latch

  task automatic t_jog;
    logic [9:0] sv [4] = '{10'h002, 10'h200, 10'h002, 10'h003};
    logic       ms [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [2:0] ex [4] = '{3'b101, 3'b111, 3'b000, 3'b001};
    for (int k = 0; k < 4; k++) begin
      stopped <= ms[k];
      bus(1'b1, 4'h0, {22'h0, sv[k] & 10'h1fd});
      st();
      bus(1'b1, 4'h0, {22'h0, sv[k]});
      st();
      chk(outs[4:2], ex[k], "jog run reverse");
      bus(1'b1, 4'h0, 32'h0);
      st();
    end
    $display("test jog done");
  endtask : t_jog

  task automatic t_limits;
    logic signed [15:0] rf [6] = '{16'sd100, 16'sd100, -16'sd100, -16'sd100, 16'sd0, 16'sd0};
    logic [2:0]         lm [6] = '{3'b101, 3'b010, 3'b011, 3'b100, 3'b101, 3'b011};
    bus(1'b1, 4'h4, 32'h871);
    bus(1'b1, 4'h8, 32'h7);
    for (int k = 0; k < 6; k++) begin
      sref <= rf[k];
      flim <= lm[k][2];
      rlim <= lm[k][1];
      repeat (2520) @(posedge clk);
      chk(outs[5], lm[k][0], "zero ramp stop");
      flim <= 1'b0;
      rlim <= 1'b0;
      repeat (2520) @(posedge clk);
      chk(outs[5], 1'b0, "stop released");
    end
    sref <= 16'sd100;
    bus(1'b1, 4'h0, 32'h20);
    wo(5, 1'b1, 2510, "limit by write");
    $display("test limits done");
  endtask : t_limits

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    avs = '0;
    sref = '0;
    stopped = 1'b0;
    trip = 1'b0;
    en_cmd = 1'b0;
    stuck = 1'b0;
    flim = 1'b0;
    rlim = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enable();
    t_schemes();
    t_latch();
    t_jog();
    t_limits();
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : test_drive_run_sequencer_enable_gating
`default_nettype wire
